// ### design/cba_core_if.v
`timescale 1ns/1ps
`include "cba_consts.vh"

module cba_core_if #(
  parameter AW = `CBA_ADDR_WIDTH
) (
  input  wire                      clock_i,
  input  wire                      rst_n_i,
  // APB slave
  input  wire                      psel_i,
  input  wire                      penable_i,
  input  wire                      pwrite_i,
  input  wire [AW-1:0]             paddr_i,
  input  wire [31:0]               pwdata_i,
  output wire [31:0]               prdata_o,
  output wire                      pready_o,
  output wire                      pslverr_o,
  // Core side transaction request
  input  wire                      txn_start_i,
  input  wire                      txn_end_i,
  input  wire                      txn_burst_i,
  input  wire                      txn_write_i,
  input  wire                      txn_addr_only_i,
  input  wire                      txn_xlate_bypass_i,
  input  wire [`CBA_PAB_WIDTH-1:0] page_attr_bits_i,
  output wire                      addr_phase_o,
  // System bus attribute pins
  output wire                      cache_inhibit_attr_n_o,
  output wire                      global_attr_n_o,
  output wire                      global_attr_oe_n_o,
  input  wire                      global_attr_n_i,
  output wire                      write_thru_attr_n_o,
  // System bus inputs
  input  wire                      tea_n_i,
  input  wire                      sreset_n_i,
  input  wire                      int_n_i,
  input  wire                      cint_n_i,
  // Core sequencing
  input  wire                      insn_done_i,
  input  wire                      stq_empty_i,
  output wire                      mchk_take_o,
  output wire                      checkstop_o,
  output wire                      ext_irq_take_o,
  output wire                      crit_irq_take_o,
  output wire                      block_complete_o,
  output wire                      drain_stq_o,
  output reg                       sreset_take_o,
  output wire                      snoop_seen_o,
  output wire                      irq_o
);

  // Hard reset release through two flops
  reg rst_meta;
  reg rst_sync;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Register file
  reg [31:0]              machine_state_reg;
  reg [`CBA_EV_WIDTH-1:0] ev_status;
  reg [`CBA_EV_WIDTH-1:0] ev_enable;
  reg [31:0]              rd_data;
  reg                     rd_err;
  reg [1:0]               sr_state;
  reg [1:0]               next_sr_state;
  reg                     sreset_q;

  wire mchk_allow_bit = machine_state_reg[`CBA_MST_MCHK_ALLOW];

  function is_reg;
    input [AW-1:0] addr;
    input [AW-1:0] ofs;
    begin
      is_reg = (addr == ofs);
    end
  endfunction

  function is_mapped;
    input [AW-1:0] addr;
    begin
      is_mapped = is_reg(addr, `CBA_OFS_MSTATE) | is_reg(addr, `CBA_OFS_STATUS) |
                  is_reg(addr, `CBA_OFS_IRQ_EN) | is_reg(addr, `CBA_OFS_IRQ_CLR) |
                  is_reg(addr, `CBA_OFS_STATE);
    end
  endfunction

  wire setup   = psel_i & ~penable_i;
  wire access  = psel_i & penable_i;
  wire wr_en   = access & pwrite_i & is_mapped(paddr_i);

  // Zero wait states; data and error were captured in the setup cycle
  assign pready_o  = 1'b1;
  assign prdata_o  = rd_data;
  assign pslverr_o = access & rd_err;

  // Attribute driver
  cba_attr_drv u_attr (
    .clock_i                (clock_i),
    .rst_n_i                (rst_sync),
    .txn_start_i            (txn_start_i),
    .txn_end_i              (txn_end_i),
    .txn_burst_i            (txn_burst_i),
    .txn_write_i            (txn_write_i),
    .txn_addr_only_i        (txn_addr_only_i),
    .txn_xlate_bypass_i     (txn_xlate_bypass_i),
    .page_attr_bits_i       (page_attr_bits_i),
    .addr_phase_o           (addr_phase_o),
    .cache_inhibit_attr_n_o (cache_inhibit_attr_n_o),
    .global_attr_n_o        (global_attr_n_o),
    .global_attr_oe_n_o     (global_attr_oe_n_o),
    .write_thru_attr_n_o    (write_thru_attr_n_o)
  );

  // Another master's snoopable transfer seen while the pin is released
  assign snoop_seen_o = global_attr_oe_n_o & ~global_attr_n_i;

  // Error and interrupt inputs
  cba_event_ctl u_event (
    .clock_i          (clock_i),
    .rst_n_i          (rst_sync),
    .tea_n_i          (tea_n_i),
    .int_n_i          (int_n_i),
    .cint_n_i         (cint_n_i),
    .mchk_allow_bit_i (mchk_allow_bit),
    .mchk_take_o      (mchk_take_o),
    .checkstop_o      (checkstop_o),
    .ext_irq_take_o   (ext_irq_take_o),
    .crit_irq_take_o  (crit_irq_take_o)
  );

  // Soft reset sequence; besides its own state it only sets the SRESET status bit, never machine_state_reg
  wire sreset_rise = ~sreset_n_i & ~sreset_q;

  always @* begin
    next_sr_state = sr_state;
    case (sr_state)
      `CBA_SR_IDLE: begin
        if (sreset_rise && !checkstop_o)
          next_sr_state = `CBA_SR_NEXT;
      end
      `CBA_SR_NEXT: begin
        // The instruction in flight may complete or raise an interrupt
        if (insn_done_i)
          next_sr_state = `CBA_SR_DRAIN;
      end
      `CBA_SR_DRAIN: begin
        if (stq_empty_i)
          next_sr_state = `CBA_SR_RECOV;
      end
      `CBA_SR_RECOV: begin
        next_sr_state = `CBA_SR_IDLE;
      end
      default: begin
        next_sr_state = `CBA_SR_IDLE;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      sr_state      <= `CBA_SR_IDLE;
      sreset_q      <= 1'b0;
      sreset_take_o <= 1'b0;
    end else begin
      sr_state      <= next_sr_state;
      sreset_q      <= ~sreset_n_i;
      sreset_take_o <= (sr_state == `CBA_SR_RECOV);
    end
  end

  // Completion held back from the same cycle in which the in-flight instruction finishes
  assign block_complete_o = (sr_state == `CBA_SR_DRAIN) |
                            (sr_state == `CBA_SR_RECOV) |
                            ((sr_state == `CBA_SR_NEXT) & insn_done_i);
  assign drain_stq_o      = (sr_state == `CBA_SR_DRAIN);

  // Event sources for the sticky status register
  wire [`CBA_EV_WIDTH-1:0] ev_set;
  assign ev_set[`CBA_EV_TEA]     = mchk_take_o;
  assign ev_set[`CBA_EV_EXT]     = ext_irq_take_o;
  assign ev_set[`CBA_EV_CRIT]    = crit_irq_take_o;
  assign ev_set[`CBA_EV_SRESET]  = sreset_take_o;
  assign ev_set[`CBA_EV_CHKSTOP] = checkstop_o;

  wire [`CBA_EV_WIDTH-1:0] ev_clr = (wr_en && is_reg(paddr_i, `CBA_OFS_IRQ_CLR)) ?
                                    pwdata_i[`CBA_EV_WIDTH-1:0] : `CBA_EV_RESET;

  assign irq_o = |(ev_status & ev_enable);

  // Hard reset is the only thing that reinitialises these
  always @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      machine_state_reg <= `CBA_MST_RESET;
      ev_status         <= `CBA_EV_RESET;
      ev_enable         <= `CBA_EV_RESET;
    end else begin
      // A new event wins over a clear in the same cycle
      ev_status <= (ev_status & ~ev_clr) | ev_set;
      if (wr_en && is_reg(paddr_i, `CBA_OFS_MSTATE))
        machine_state_reg <= pwdata_i;
      if (wr_en && is_reg(paddr_i, `CBA_OFS_IRQ_EN))
        ev_enable <= pwdata_i[`CBA_EV_WIDTH-1:0];
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  reg [31:0] next_rd_data;

  always @* begin
    next_rd_data = 32'h0000_0000;
    case (paddr_i)
      `CBA_OFS_MSTATE: begin
        next_rd_data = machine_state_reg;
      end
      `CBA_OFS_STATUS: begin
        next_rd_data[`CBA_EV_WIDTH-1:0] = ev_status;
      end
      `CBA_OFS_IRQ_EN: begin
        next_rd_data[`CBA_EV_WIDTH-1:0] = ev_enable;
      end
      `CBA_OFS_STATE: begin
        next_rd_data[0] = checkstop_o;
        next_rd_data[1] = addr_phase_o;
        next_rd_data[2] = ~cache_inhibit_attr_n_o;
        next_rd_data[3] = ~global_attr_n_o;
        next_rd_data[4] = ~write_thru_attr_n_o;
        next_rd_data[6:5] = sr_state;
      end
      default: begin
        next_rd_data = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      rd_data <= 32'h0000_0000;
      rd_err  <= 1'b0;
    end else if (setup) begin
      rd_data <= pwrite_i ? 32'h0000_0000 : next_rd_data;
      rd_err  <= ~is_mapped(paddr_i);
    end
  end

endmodule // cba_core_if

// ### design/cba_consts.vh
`ifndef CBA_CONSTS_VH
`define CBA_CONSTS_VH

// Page attribute bit positions within page_attr_bits (W I M G)
`define CBA_PAB_W          3
`define CBA_PAB_I          2
`define CBA_PAB_M          1
`define CBA_PAB_G          0
`define CBA_PAB_WIDTH      4

// APB register byte offsets
`define CBA_ADDR_WIDTH     8
`define CBA_OFS_MSTATE     8'h00
`define CBA_OFS_STATUS     8'h04
`define CBA_OFS_IRQ_EN     8'h08
`define CBA_OFS_IRQ_CLR    8'h0C
`define CBA_OFS_STATE      8'h10

// machine_state_reg fields
`define CBA_MST_MCHK_ALLOW 0
`define CBA_MST_RESET      32'h0000_0001

// Event status bits (status, enable and clear share the layout)
`define CBA_EV_WIDTH       5
`define CBA_EV_TEA         0
`define CBA_EV_EXT         1
`define CBA_EV_CRIT        2
`define CBA_EV_SRESET      3
`define CBA_EV_CHKSTOP     4
`define CBA_EV_RESET       5'h00

// Soft reset sequence states
`define CBA_SR_IDLE        2'h0
`define CBA_SR_NEXT        2'h1
`define CBA_SR_DRAIN       2'h2
`define CBA_SR_RECOV       2'h3

`endif

// ### design/cba_attr_drv.v
`timescale 1ns/1ps
`include "cba_consts.vh"

module cba_attr_drv (
  input  wire                      clock_i,
  input  wire                      rst_n_i,
  input  wire                      txn_start_i,
  input  wire                      txn_end_i,
  input  wire                      txn_burst_i,
  input  wire                      txn_write_i,
  input  wire                      txn_addr_only_i,
  input  wire                      txn_xlate_bypass_i,
  input  wire [`CBA_PAB_WIDTH-1:0] page_attr_bits_i,
  output reg                       addr_phase_o,
  output reg                       cache_inhibit_attr_n_o,
  output reg                       global_attr_n_o,
  output reg                       global_attr_oe_n_o,
  output reg                       write_thru_attr_n_o
);

  wire burst_wr = txn_burst_i & txn_write_i;
  // Inhibit follows the page bit except on burst writes and address-only transfers
  wire inh_set  = page_attr_bits_i[`CBA_PAB_I] & ~burst_wr & ~txn_addr_only_i;
  wire gbl_set  = (txn_addr_only_i & txn_xlate_bypass_i) ? 1'b1 :
                  burst_wr ? 1'b0 : page_attr_bits_i[`CBA_PAB_M];
  wire wthru_set = ~txn_burst_i & page_attr_bits_i[`CBA_PAB_W];

  // Captured once at the start and frozen until the phase ends
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_phase_o           <= 1'b0;
      cache_inhibit_attr_n_o <= 1'b1;
      global_attr_n_o        <= 1'b1;
      global_attr_oe_n_o     <= 1'b1;
      write_thru_attr_n_o    <= 1'b1;
    end else if (txn_start_i && !addr_phase_o) begin
      addr_phase_o           <= 1'b1;
      cache_inhibit_attr_n_o <= ~inh_set;
      global_attr_n_o        <= ~gbl_set;
      global_attr_oe_n_o     <= 1'b0;
      write_thru_attr_n_o    <= ~wthru_set;
    end else if (txn_end_i && addr_phase_o) begin
      addr_phase_o           <= 1'b0;
      cache_inhibit_attr_n_o <= 1'b1;
      global_attr_n_o        <= 1'b1;
      global_attr_oe_n_o     <= 1'b1;
      write_thru_attr_n_o    <= 1'b1;
    end
  end

endmodule // cba_attr_drv

// ### design/cba_event_ctl.v
`timescale 1ns/1ps
`include "cba_consts.vh"

module cba_event_ctl (
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire tea_n_i,
  input  wire int_n_i,
  input  wire cint_n_i,
  input  wire mchk_allow_bit_i,
  output reg  mchk_take_o,
  output reg  checkstop_o,
  output reg  ext_irq_take_o,
  output reg  crit_irq_take_o
);

  reg tea_q;
  reg int_q;
  reg cint_q;

  // Active-low inputs: assertion is the high-to-low step
  wire tea_rise  = ~tea_n_i & ~tea_q;
  wire int_rise  = ~int_n_i & ~int_q;
  wire cint_rise = ~cint_n_i & ~cint_q;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tea_q           <= 1'b0;
      int_q           <= 1'b0;
      cint_q          <= 1'b0;
      mchk_take_o     <= 1'b0;
      checkstop_o     <= 1'b0;
      ext_irq_take_o  <= 1'b0;
      crit_irq_take_o <= 1'b0;
    end else begin
      tea_q           <= ~tea_n_i;
      int_q           <= ~int_n_i;
      cint_q          <= ~cint_n_i;
      // Once stopped, nothing more is serviced until hard reset
      mchk_take_o     <= tea_rise & mchk_allow_bit_i & ~checkstop_o;
      if (tea_rise && !mchk_allow_bit_i)
        checkstop_o   <= 1'b1;
      ext_irq_take_o  <= int_rise & ~checkstop_o;
      crit_irq_take_o <= cint_rise & ~checkstop_o;
    end
  end

endmodule // cba_event_ctl

// ### test/cba_checker.sv
`timescale 1ns/1ps
`include "cba_consts.vh"

module cba_checker (
  input wire                      clock_i,
  input wire                      rst_n_i,
  input wire                      txn_start_i,
  input wire                      txn_end_i,
  input wire                      txn_burst_i,
  input wire                      txn_write_i,
  input wire                      txn_addr_only_i,
  input wire                      txn_xlate_bypass_i,
  input wire [`CBA_PAB_WIDTH-1:0] page_attr_bits_i,
  input wire                      addr_phase_o,
  input wire                      cache_inhibit_attr_n_o,
  input wire                      global_attr_n_o,
  input wire                      global_attr_oe_n_o,
  input wire                      global_attr_n_i,
  input wire                      write_thru_attr_n_o,
  input wire                      tea_n_i,
  input wire                      int_n_i,
  input wire                      cint_n_i,
  input wire                      stq_empty_i,
  input wire                      mchk_take_o,
  input wire                      checkstop_o,
  input wire                      ext_irq_take_o,
  input wire                      crit_irq_take_o,
  input wire                      block_complete_o,
  input wire                      drain_stq_o,
  input wire                      snoop_seen_o
);
  wire       bw   = txn_burst_i & txn_write_i;
  wire       in_e = page_attr_bits_i[`CBA_PAB_I] & ~bw & ~txn_addr_only_i;
  wire       gb_e = (txn_addr_only_i & txn_xlate_bypass_i) | (~bw & page_attr_bits_i[`CBA_PAB_M]);
  wire       wr_e = ~txn_burst_i & page_attr_bits_i[`CBA_PAB_W];
  wire       take = txn_start_i & ~addr_phase_o;
  wire [2:0] pins = {cache_inhibit_attr_n_o, global_attr_n_o, write_thru_attr_n_o};

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_inhibit_follow: assert property (take |=> cache_inhibit_attr_n_o == !$past(in_e))
    else $error("cache inhibit attribute wrong");
  chk_gbl_follow: assert property (take |=> !global_attr_oe_n_o && global_attr_n_o == !$past(gb_e))
    else $error("global attribute wrong");
  chk_wthru_follow: assert property (take |=> addr_phase_o && write_thru_attr_n_o == !$past(wr_e))
    else $error("write-through attribute wrong");
  chk_attr_stable: assert property (addr_phase_o && !txn_end_i |=> addr_phase_o && $stable(pins))
    else $error("attributes moved inside the address phase");
  chk_idle_negated: assert property (!addr_phase_o |-> pins == 3'h7 && global_attr_oe_n_o)
    else $error("attribute asserted outside a phase");
  chk_snoop_seen: assert property (snoop_seen_o == (global_attr_oe_n_o && !global_attr_n_i))
    else $error("snoop flag wrong");
  chk_mchk_take: assert property ($fell(tea_n_i) && !checkstop_o |-> ##[1:3] (mchk_take_o || checkstop_o))
    else $error("transfer error not taken");
  chk_ext_take: assert property ($fell(int_n_i) && !checkstop_o |-> ##[1:3] ext_irq_take_o)
    else $error("external interrupt not taken");
  chk_crit_take: assert property ($fell(cint_n_i) && !checkstop_o |-> ##[1:3] crit_irq_take_o)
    else $error("critical interrupt not taken");
  chk_stop_sticky: assert property (checkstop_o |=> checkstop_o)
    else $error("checkstop dropped");
  chk_stop_quiet: assert property (checkstop_o && $past(checkstop_o, 3) |-> !(mchk_take_o || ext_irq_take_o || crit_irq_take_o))
    else $error("interrupt taken in checkstop");
  chk_drain_block: assert property (drain_stq_o |-> block_complete_o)
    else $error("completion not blocked while draining");
  chk_drain_hold: assert property (drain_stq_o && !stq_empty_i |=> drain_stq_o)
    else $error("drain ended early");
endmodule // cba_checker

bind cba_core_if cba_checker u_chk (
  .clock_i, .rst_n_i, .txn_start_i, .txn_end_i, .txn_burst_i, .txn_write_i, .txn_addr_only_i,
  .txn_xlate_bypass_i, .page_attr_bits_i, .addr_phase_o, .cache_inhibit_attr_n_o,
  .global_attr_n_o, .global_attr_oe_n_o, .global_attr_n_i, .write_thru_attr_n_o, .tea_n_i,
  .int_n_i, .cint_n_i, .stq_empty_i, .mchk_take_o, .checkstop_o, .ext_irq_take_o,
  .crit_irq_take_o, .block_complete_o, .drain_stq_o, .snoop_seen_o
);

// ### test/cba_sys_model.sv
`timescale 1ns/1ps

module cba_sys_model (
  input  wire       clock_i,
  input  wire [3:0] ev_req_i,
  input  wire       snoop_i,
  input  wire       gbl_n_i,
  input  wire       gbl_oe_n_i,
  output reg  [3:0] ev_n_o,
  output wire       gbl_pin_n_o
);
  // Event lines: [0] transfer error, [1] external, [2] critical, [3] soft reset
  initial ev_n_o = 4'hF;
  always @(posedge clock_i) begin
    ev_n_o <= ~ev_req_i;
  end
  // Pulled-up shared line: other masters only assert it while the core has let go
  assign gbl_pin_n_o = !gbl_oe_n_i ? gbl_n_i : !snoop_i;
endmodule // cba_sys_model

// ### test/testbench.sv
`timescale 1ns/1ps
`include "cba_consts.vh"

module testbench;
  reg         clock_i   = 1'b0;
  reg         rst_n     = 1'b0;
  reg         psel      = 1'b0;
  reg         penable   = 1'b0;
  reg         pwrite    = 1'b0;
  reg  [7:0]  paddr     = 8'h00;
  reg  [31:0] pwdata    = 32'h0;
  reg  [3:0]  ctl       = 4'h0;
  reg  [3:0]  page      = 4'h0;
  reg         t_start   = 1'b0;
  reg         t_end     = 1'b0;
  reg  [3:0]  ev_req    = 4'h0;
  reg         snoop     = 1'b0;
  reg         insn_done = 1'b0;
  reg         stq_empty = 1'b0;
  reg  [7:0]  rnd       = 8'h3C;
  reg  [31:0] q;
  reg         e;
  reg  [5:0]  i;
  integer     k;
  integer     failures  = 0;
  integer     compares  = 0;
  wire [31:0] prdata;
  wire [3:0]  ev_n;
  wire        pready, pslverr, aph, inh_n, gbl_n, gbl_oe_n, gbl_pin_n, wthru_n;
  wire        mchk, cstop, ext, crit, blk, drain, sr_take, snp, irq;

  always #50 clock_i = ~clock_i;

  cba_core_if u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .txn_start_i(t_start), .txn_end_i(t_end), .txn_burst_i(ctl[3]),
    .txn_write_i(ctl[2]), .txn_addr_only_i(ctl[1]), .txn_xlate_bypass_i(ctl[0]),
    .page_attr_bits_i(page), .addr_phase_o(aph), .cache_inhibit_attr_n_o(inh_n),
    .global_attr_n_o(gbl_n), .global_attr_oe_n_o(gbl_oe_n), .global_attr_n_i(gbl_pin_n),
    .write_thru_attr_n_o(wthru_n), .tea_n_i(ev_n[0]), .int_n_i(ev_n[1]), .cint_n_i(ev_n[2]),
    .sreset_n_i(ev_n[3]), .insn_done_i(insn_done), .stq_empty_i(stq_empty),
    .mchk_take_o(mchk), .checkstop_o(cstop), .ext_irq_take_o(ext), .crit_irq_take_o(crit),
    .block_complete_o(blk), .drain_stq_o(drain), .sreset_take_o(sr_take),
    .snoop_seen_o(snp), .irq_o(irq)
  );
  cba_sys_model u_sys (
    .clock_i(clock_i), .ev_req_i(ev_req), .snoop_i(snoop), .gbl_n_i(gbl_n),
    .gbl_oe_n_i(gbl_oe_n), .ev_n_o(ev_n), .gbl_pin_n_o(gbl_pin_n)
  );

  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Asserted levels {ci, gbl, wt}; c is {burst, write, address-only, bypass}
  function [2:0] attr_exp(input [3:0] c, input [3:0] p);
    begin
      attr_exp[2] = p[`CBA_PAB_I] & ~(c[3] & c[2]) & ~c[1];
      attr_exp[1] = (c[1] & c[0]) | (~(c[3] & c[2]) & p[`CBA_PAB_M]);
      attr_exp[0] = ~c[3] & p[`CBA_PAB_W];
    end
  endfunction
  function took(input integer n);
    took = n == 0 ? mchk : n == 1 ? ext : n == 2 ? crit : n == 3 ? sr_take : cstop;
  endfunction

  task check_word(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t word got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check_bit(input got, input exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  task apb(input wr, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock_i);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      @(posedge clock_i);
      while (pready !== 1'b1 && n < 16) begin
        @(posedge clock_i);
        n = n + 1;
      end
      // A slave that never answers counts against the run
      if (n == 16)
        failures = failures + 1;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp, input exp_err);
    begin
      apb(1'b0, a, 32'h0);
      check_word(q, exp);
      check_bit(e, exp_err);
    end
  endtask
  task reset_chk;
    begin
      rst_n <= 1'b0;
      repeat (4) @(posedge clock_i);
      check_bit(cstop, 1'b0);
      rst_n <= 1'b1;
      repeat (6) @(posedge clock_i);
      rd_chk(`CBA_OFS_MSTATE, `CBA_MST_RESET, 1'b0);
      rd_chk(`CBA_OFS_STATUS, 32'h0, 1'b0);
      rd_chk(`CBA_OFS_IRQ_EN, 32'h0, 1'b0);
    end
  endtask

  // Second start inside the phase carries inverted page bits and must be ignored
  task txn(input [3:0] c, input [3:0] p);
    reg [2:0] x;
    begin
      x = attr_exp(c, p);
      @(posedge clock_i);
      ctl     <= c;
      page    <= p;
      t_start <= 1'b1;
      @(posedge clock_i);
      page    <= ~p;
      @(posedge clock_i);
      t_start <= 1'b0;
      snoop   <= 1'b1;
      @(negedge clock_i);
      check_word({28'h0, aph, inh_n, gbl_n, wthru_n}, {29'h1, ~x});
      check_bit(gbl_pin_n, ~x[1]);
      @(posedge clock_i);
      t_end   <= 1'b1;
      @(posedge clock_i);
      t_end   <= 1'b0;
      @(negedge clock_i);
      check_word({28'h0, aph, inh_n, gbl_oe_n, wthru_n}, 32'h7);
      check_bit(snp, 1'b1);
      @(posedge clock_i);
      snoop   <= 1'b0;
    end
  endtask

  task raise(input integer n);
    begin
      @(posedge clock_i);
      ev_req[n] <= 1'b1;
      repeat (2) @(posedge clock_i);
      ev_req[n] <= 1'b0;
    end
  endtask
  task wait_hi(input integer n);
    integer c;
    begin
      c = 0;
      while (took(n) !== 1'b1 && c < 24) begin
        @(negedge clock_i);
        c = c + 1;
      end
      check_bit(took(n), 1'b1);
    end
  endtask

  initial begin
    #500000;
    failures = failures + 1;
    results;
  end

  initial begin
    reset_chk;
    rd_chk(`CBA_OFS_IRQ_CLR, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    for (i = 0; i < 48; i = i + 1) begin
      txn(i < 32 ? i[3:0] : rnd[3:0], i < 32 ? {4{i[4]}} : rnd[7:4]);
      rnd = lfsr(rnd);
    end
    // External interrupt stays masked to see status set without the output
    apb(1'b1, `CBA_OFS_IRQ_EN, 32'h1D);
    for (k = 0; k < 3; k = k + 1) begin
      fork
        raise(k);
        wait_hi(k);
      join
      repeat (2) @(posedge clock_i);
      rd_chk(`CBA_OFS_STATUS, 32'h1 << k, 1'b0);
      check_bit(irq, k != 1);
      apb(1'b1, `CBA_OFS_IRQ_CLR, 32'h1 << k);
      rd_chk(`CBA_OFS_STATUS, 32'h0, 1'b0);
      check_bit(irq, 1'b0);
    end
    apb(1'b1, `CBA_OFS_MSTATE, 32'h5A5A_00F1);
    fork
      raise(3);
      wait_hi(3);
      begin
        repeat (6) @(posedge clock_i);
        insn_done <= 1'b1;
        repeat (4) @(posedge clock_i);
        check_word({30'h0, blk, drain}, 32'h3);
        stq_empty <= 1'b1;
      end
    join
    repeat (2) @(posedge clock_i);
    rd_chk(`CBA_OFS_MSTATE, 32'h5A5A_00F1, 1'b0);
    rd_chk(`CBA_OFS_STATUS, 32'h8, 1'b0);
    insn_done <= 1'b0;
    stq_empty <= 1'b0;
    apb(1'b1, `CBA_OFS_MSTATE, 32'h0);
    fork
      raise(0);
      wait_hi(4);
    join
    fork
      raise(1);
      repeat (8) begin
        @(negedge clock_i);
        check_bit(ext, 1'b0);
      end
    join
    apb(1'b0, `CBA_OFS_STATUS, 32'h0);
    check_word(q & 32'h13, 32'h10);
    reset_chk;
    results;
  end
endmodule // testbench
